// file: src/sptc_defs.svh
// offsets, field positions, reset values and timing counts of the serial port
`ifndef SPTC_DEFS_SVH
`define SPTC_DEFS_SVH
`define SPTC_ADDR_TX_CTL 8'h00
`define SPTC_ADDR_RX_CTL 8'h01
`define SPTC_ADDR_BAUD 8'h02
`define SPTC_ADDR_RX_DATA 8'h03
`define SPTC_ADDR_TX_DATA 8'h04
`define SPTC_ADDR_INT_STAT 8'h05
`define SPTC_ADDR_INT_MASK 8'h06
`define SPTC_TX_CLK_SRC 7
`define SPTC_TX_NINE 6
`define SPTC_TX_EN 5
`define SPTC_TX_SYNC 4
`define SPTC_TX_HIGH_SPEED 2
`define SPTC_TX_EMPTY 1
`define SPTC_TX_NINTH 0
`define SPTC_RX_PORT_EN 7
`define SPTC_RX_NINE 6
`define SPTC_RX_SINGLE 5
`define SPTC_RX_CONT 4
`define SPTC_RX_ADDR_DET 3
`define SPTC_RX_FRAME_ERR 2
`define SPTC_RX_OVERRUN 1
`define SPTC_RX_NINTH 0
`define SPTC_INT_RX_CHAR 0
`define SPTC_INT_TX_DONE 1
`define SPTC_INT_OVERRUN 2
`define SPTC_INT_FRAME_ERR 3
`define SPTC_TX_CTL_RESET 8'h02
`define SPTC_RX_CTL_RESET 8'h00
`define SPTC_BAUD_RESET 8'h00
`define SPTC_OVS_LAST_ASYNC 4'hF
`define SPTC_OVS_LAST_SYNC 4'h3
`define SPTC_OVS_MID_ASYNC 4'h7
`define SPTC_LAST_BIT_NINE 4'h8
`define SPTC_LAST_BIT_EIGHT 4'h7
`define SPTC_FIFO_DEPTH 2
`endif

// file: src/sptc_pkg.sv
// types shared by the serial port modules
package sptc_pkg;
  typedef logic [7:0] sptc_byte_t;
  typedef logic [3:0] sptc_nib_t;
  typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} sptc_tx_state_t;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} sptc_rx_state_t;
endpackage : sptc_pkg

// file: src/sptc_baud_if.sv
// carrier between the port logic and its baud generator
`timescale 1ns/1ps
interface sptc_baud_if;
  logic [7:0] divisor;
  logic high_speed;
  logic sync_mode;
  logic run;
  logic tick;
  modport gen (input divisor, input high_speed, input sync_mode, input run, output tick);
  modport user (output divisor, output high_speed, output sync_mode, output run, input tick);
endinterface : sptc_baud_if

// file: src/sptc_baud_gen.sv
// baud generator: one-cycle oversample tick from the divisor
`timescale 1ns/1ps
module sptc_baud_gen (
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // settings and tick
  sptc_baud_if.gen bif
);
  import sptc_pkg::*;
  logic [9:0] cnt;
  logic [9:0] reload;
  // low speed async stretches the period four times, sync and high speed do not
  always_comb begin
    if (!bif.sync_mode && !bif.high_speed) begin
      reload = {bif.divisor, 2'b11};
    end else begin
      reload = {2'b00, bif.divisor};
    end
  end
  // down counter, tick on zero
  always_ff @(posedge core_clk) begin
    if (srst || !bif.run) begin
      cnt <= 10'h000;
      bif.tick <= 1'b0;
    end else if (cnt == 10'h000) begin
      cnt <= reload;
      bif.tick <= 1'b1;
    end else begin
      cnt <= cnt - 10'h001;
      bif.tick <= 1'b0;
    end
  end
endmodule : sptc_baud_gen

// file: src/sptc_serial_port.sv
// serial port: transmit control, async receive path, register port, interrupts
// What this block does
// (RL1) sync mode: clock select set means master from baud generator, clear means slave
// (RL2) nine-bit select picks 9-bit characters when set, 8-bit when clear
// (RL3) transmitter runs only while transmit enable is set
// (RL4) mode field picks synchronous when set, asynchronous when clear
// (RL5) bit 3 of transmit control reads zero, writes ignored
// (RL6) async: speed select picks high or low baud; ignored in sync mode
// (RL7) shift register empty is read-only, resets to one, zero while busy
// (RL8) ninth transmit bit goes out as ninth data bit of 9-bit characters
// (RL9) reset clears all writable transmit control fields, empty flag one
// (RL10) receive flag set while receiver enabled and unread character waits
// (RL11) software enables port and keeps mode clear before async reception
// (RL12) control writes take effect on the clock edge after the write
//
// Implementation choices: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`include "sptc_defs.svh"
module sptc_serial_port (
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // register port
  input wire sptc_pkg::sptc_byte_t reg_addr,
  input wire sptc_pkg::sptc_byte_t reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output sptc_pkg::sptc_byte_t reg_rdata,
  // serial line
  input wire logic rx_line_in,
  output logic tx_line_out,
  output logic tx_line_oe,
  input wire logic sclk_in,
  output logic sclk_out,
  output logic sclk_oe,
  // interrupts
  output logic receive_interrupt_flag,
  output logic irq
);
  import sptc_pkg::*;
  // transmit control fields
  logic clock_source_select;
  logic nine_bit_tx_select;
  logic transmit_enable_field;
  logic sync_mode;
  logic baud_speed_select;
  logic tx_ninth_bit;
  // receive control fields
  logic serial_port_enable;
  logic rx_nine;
  logic rx_single;
  logic rx_cont;
  logic rx_addr_det;
  logic rx_overrun;
  sptc_byte_t baud_rate_divisor;
  sptc_byte_t tx_hold;
  logic tx_hold_full;
  logic [3:0] int_stat;
  logic [3:0] int_mask;
  logic [3:0] int_ev;
  // transmitter state
  sptc_tx_state_t tx_state;
  logic [8:0] transmit_shift_register;
  sptc_nib_t tx_ovs;
  sptc_nib_t tx_cnt;
  logic tx_bit_end;
  logic tx_done;
  logic tx_load;
  logic shift_register_empty;
  logic next_tx_line;
  logic next_sclk;
  // receiver state
  sptc_rx_state_t rx_state;
  logic [8:0] rx_shift;
  sptc_nib_t rx_ovs;
  sptc_nib_t rx_cnt;
  logic rx_run;
  logic rx_char_end;
  logic rx_keep;
  logic rx_push;
  logic rx_pop;
  logic rx_ferr_ev;
  logic rx_ovr_ev;
  logic [9:0] rx_word;
  logic [9:0] rx_fifo [`SPTC_FIFO_DEPTH];
  logic rx_wp;
  logic rx_rp;
  logic [1:0] rx_count;
  // pin synchronisers
  logic rx_s1, rx_s2, rx_s3, rx_f, rx_f_d;
  logic ck_s1, ck_s2, ck_s3, ck_f, ck_f_d;
  logic ck_fall;
  logic wr_tx_ctl;
  sptc_byte_t tx_ctl_view;
  sptc_byte_t rx_ctl_view;

  sptc_baud_if bif ();
  // baud settings steered by the control fields
  assign bif.divisor = baud_rate_divisor;
  // (RL6) speed select used in async only
  assign bif.high_speed = baud_speed_select;
  assign bif.sync_mode = sync_mode;
  assign bif.run = serial_port_enable;
  sptc_baud_gen u_baud (
    .core_clk (core_clk),
    .srst (srst),
    .bif (bif)
  );

  // register views, unimplemented bit forced low
  assign wr_tx_ctl = reg_wr && (reg_addr == `SPTC_ADDR_TX_CTL);
  // (RL5) bit 3 always zero
  assign tx_ctl_view = {clock_source_select, nine_bit_tx_select, transmit_enable_field,
                        sync_mode, 1'b0, baud_speed_select, shift_register_empty, tx_ninth_bit};
  assign rx_ctl_view = {serial_port_enable, rx_nine, rx_single, rx_cont, rx_addr_det,
                        rx_fifo[rx_rp][9] & (rx_count != 2'b00), rx_overrun,
                        rx_fifo[rx_rp][8] & (rx_count != 2'b00)};

  // (RL9) writable fields reset to zero
  // (RL12) write lands on the edge of the strobe
  always_ff @(posedge core_clk) begin
    if (srst) begin
      clock_source_select <= 1'b0;
      nine_bit_tx_select <= 1'b0;
      transmit_enable_field <= 1'b0;
      sync_mode <= 1'b0;
      baud_speed_select <= 1'b0;
      tx_ninth_bit <= 1'b0;
    end else if (wr_tx_ctl) begin
      clock_source_select <= reg_wdata[`SPTC_TX_CLK_SRC];
      nine_bit_tx_select <= reg_wdata[`SPTC_TX_NINE];
      transmit_enable_field <= reg_wdata[`SPTC_TX_EN];
      sync_mode <= reg_wdata[`SPTC_TX_SYNC];
      baud_speed_select <= reg_wdata[`SPTC_TX_HIGH_SPEED];
      tx_ninth_bit <= reg_wdata[`SPTC_TX_NINTH];
    end
  end

  // receive control and divisor; status bits are not writable
  always_ff @(posedge core_clk) begin
    if (srst) begin
      {serial_port_enable, rx_nine, rx_single, rx_cont, rx_addr_det} <= 5'h00;
      baud_rate_divisor <= `SPTC_BAUD_RESET;
    end else if (reg_wr && (reg_addr == `SPTC_ADDR_RX_CTL)) begin
      serial_port_enable <= reg_wdata[`SPTC_RX_PORT_EN];
      rx_nine <= reg_wdata[`SPTC_RX_NINE];
      rx_single <= reg_wdata[`SPTC_RX_SINGLE];
      rx_cont <= reg_wdata[`SPTC_RX_CONT];
      rx_addr_det <= reg_wdata[`SPTC_RX_ADDR_DET];
    end else if (reg_wr && (reg_addr == `SPTC_ADDR_BAUD)) begin
      baud_rate_divisor <= reg_wdata;
    end
  end

  // transmit holding buffer, a new write overwrites an unsent byte
  always_ff @(posedge core_clk) begin
    if (srst) begin
      tx_hold <= 8'h00;
      tx_hold_full <= 1'b0;
    end else if (reg_wr && (reg_addr == `SPTC_ADDR_TX_DATA)) begin
      tx_hold <= reg_wdata;
      tx_hold_full <= 1'b1;
    end else if (tx_load) begin
      tx_hold_full <= 1'b0;
    end
  end

  // read data one cycle after the strobe; unmapped reads return zero
  always_ff @(posedge core_clk) begin
    if (srst) begin
      reg_rdata <= 8'h00;
    end else if (!reg_rd) begin
      reg_rdata <= 8'h00;
    end else if (reg_addr == `SPTC_ADDR_TX_CTL) begin
      reg_rdata <= tx_ctl_view;
    end else if (reg_addr == `SPTC_ADDR_RX_CTL) begin
      reg_rdata <= rx_ctl_view;
    end else if (reg_addr == `SPTC_ADDR_BAUD) begin
      reg_rdata <= baud_rate_divisor;
    end else if (reg_addr == `SPTC_ADDR_RX_DATA) begin
      reg_rdata <= (rx_count != 2'b00) ? rx_fifo[rx_rp][7:0] : 8'h00;
    end else if (reg_addr == `SPTC_ADDR_INT_STAT) begin
      reg_rdata <= {4'h0, int_stat};
    end else if (reg_addr == `SPTC_ADDR_INT_MASK) begin
      reg_rdata <= {4'h0, int_mask};
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // three-stage pin synchronisers; value moves once stages two and three agree
  always_ff @(posedge core_clk) begin
    if (srst) begin
      {rx_s1, rx_s2, rx_s3, rx_f, rx_f_d} <= 5'h1F;
      {ck_s1, ck_s2, ck_s3, ck_f, ck_f_d} <= 5'h00;
    end else begin
      {rx_s1, rx_s2, rx_s3} <= {rx_line_in, rx_s1, rx_s2};
      {ck_s1, ck_s2, ck_s3} <= {sclk_in, ck_s1, ck_s2};
      rx_f <= (rx_s2 == rx_s3) ? rx_s3 : rx_f;
      ck_f <= (ck_s2 == ck_s3) ? ck_s3 : ck_f;
      rx_f_d <= rx_f;
      ck_f_d <= ck_f;
    end
  end
  assign ck_fall = ck_f_d && !ck_f;

  // (RL1) slave shifts on external falling edges, master on its own ticks
  // (RL4) sync uses four ticks per bit, async sixteen
  always_comb begin
    if (sync_mode && !clock_source_select) begin
      tx_bit_end = ck_fall;
    end else if (sync_mode) begin
      tx_bit_end = bif.tick && (tx_ovs == `SPTC_OVS_LAST_SYNC);
    end else begin
      tx_bit_end = bif.tick && (tx_ovs == `SPTC_OVS_LAST_ASYNC);
    end
  end
  // (RL3) a character only starts while enabled
  assign tx_load = (tx_state == TX_IDLE) && tx_hold_full && transmit_enable_field
                   && serial_port_enable;
  // (RL7) empty whenever nothing is in the shifter
  assign shift_register_empty = (tx_state == TX_IDLE);

  // transmit sequencer
  always_ff @(posedge core_clk) begin
    if (srst) begin
      tx_state <= TX_IDLE;
      transmit_shift_register <= 9'h000;
      tx_ovs <= 4'h0;
      tx_cnt <= 4'h0;
      tx_done <= 1'b0;
    end else begin
      tx_done <= 1'b0;
      if (bif.tick && tx_state != TX_IDLE) begin
        tx_ovs <= tx_bit_end ? 4'h0 : tx_ovs + 4'h1;
      end
      // (RL3) clearing enable aborts the character
      if (!transmit_enable_field || !serial_port_enable) begin
        tx_state <= TX_IDLE;
      end else begin
        case (tx_state)
          TX_IDLE: begin
            if (tx_load) begin
              // (RL8) ninth bit rides above the data byte
              transmit_shift_register <= {tx_ninth_bit, tx_hold};
              tx_ovs <= 4'h0;
              tx_cnt <= 4'h0;
              tx_state <= sync_mode ? TX_DATA : TX_START;
            end
          end
          TX_START: begin
            if (tx_bit_end) begin
              tx_state <= TX_DATA;
            end
          end
          TX_DATA: begin
            if (tx_bit_end) begin
              transmit_shift_register <= {1'b0, transmit_shift_register[8:1]};
              tx_cnt <= tx_cnt + 4'h1;
              // (RL2) eight or nine data bits
              if (tx_cnt == (nine_bit_tx_select ? `SPTC_LAST_BIT_NINE : `SPTC_LAST_BIT_EIGHT))
              begin
                tx_state <= sync_mode ? TX_IDLE : TX_STOP;
                tx_done <= sync_mode;
              end
            end
          end
          TX_STOP: begin
            if (tx_bit_end) begin
              tx_state <= TX_IDLE;
              tx_done <= 1'b1;
            end
          end
          default: tx_state <= TX_IDLE;
        endcase
      end
    end
  end

  // line levels, registered so the pins never glitch
  always_comb begin
    case (tx_state)
      TX_START: next_tx_line = 1'b0;
      TX_DATA: next_tx_line = transmit_shift_register[0];
      default: next_tx_line = 1'b1;
    endcase
    // (RL1) master drives the clock, low half then high half of each bit
    next_sclk = sync_mode && clock_source_select && (tx_state == TX_DATA) && tx_ovs[1];
  end
  always_ff @(posedge core_clk) begin
    if (srst) begin
      tx_line_out <= 1'b1;
      tx_line_oe <= 1'b0;
      sclk_out <= 1'b0;
      sclk_oe <= 1'b0;
    end else begin
      tx_line_out <= next_tx_line;
      tx_line_oe <= serial_port_enable && transmit_enable_field;
      sclk_out <= next_sclk;
      sclk_oe <= serial_port_enable && sync_mode && clock_source_select;
    end
  end

  // (RL11) receiver only listens in async mode with the port enabled
  assign rx_run = serial_port_enable && rx_cont && !sync_mode && !rx_overrun;
  assign rx_char_end = (rx_state == RX_STOP) && bif.tick && (rx_ovs == `SPTC_OVS_LAST_ASYNC);
  // address detect drops characters whose ninth bit is clear
  assign rx_keep = !(rx_addr_det && rx_nine && !rx_shift[8]);
  assign rx_push = rx_char_end && rx_keep && (rx_count != 2'b10);
  assign rx_ovr_ev = rx_char_end && rx_keep && (rx_count == 2'b10);
  assign rx_ferr_ev = rx_push && !rx_f;
  assign rx_pop = reg_rd && (reg_addr == `SPTC_ADDR_RX_DATA) && (rx_count != 2'b00);
  assign rx_word = rx_nine ? {!rx_f, rx_shift} : {!rx_f, 1'b0, rx_shift[8:1]};

  // receive sequencer, mid-bit sampling on the oversample grid
  always_ff @(posedge core_clk) begin
    if (srst || !rx_run) begin
      rx_state <= RX_IDLE;
      rx_shift <= 9'h000;
      rx_ovs <= 4'h0;
      rx_cnt <= 4'h0;
    end else begin
      case (rx_state)
        RX_IDLE: begin
          if (rx_f_d && !rx_f) begin
            rx_ovs <= 4'h0;
            rx_state <= RX_START;
          end
        end
        RX_START: begin
          if (bif.tick) begin
            rx_ovs <= rx_ovs + 4'h1;
            if (rx_ovs == `SPTC_OVS_MID_ASYNC) begin
              rx_ovs <= 4'h0;
              rx_cnt <= 4'h0;
              rx_state <= rx_f ? RX_IDLE : RX_DATA;
            end
          end
        end
        RX_DATA: begin
          if (bif.tick) begin
            rx_ovs <= rx_ovs + 4'h1;
            if (rx_ovs == `SPTC_OVS_LAST_ASYNC) begin
              rx_shift <= {rx_f, rx_shift[8:1]};
              rx_cnt <= rx_cnt + 4'h1;
              if (rx_cnt == (rx_nine ? `SPTC_LAST_BIT_NINE : `SPTC_LAST_BIT_EIGHT)) begin
                rx_state <= RX_STOP;
              end
            end
          end
        end
        RX_STOP: begin
          if (bif.tick) begin
            rx_ovs <= rx_ovs + 4'h1;
            if (rx_char_end) begin
              rx_state <= RX_IDLE;
            end
          end
        end
        default: rx_state <= RX_IDLE;
      endcase
    end
  end

  // two-entry receive fifo; disabling the port flushes it
  always_ff @(posedge core_clk) begin
    if (srst || !serial_port_enable) begin
      rx_wp <= 1'b0;
      rx_rp <= 1'b0;
      rx_count <= 2'b00;
    end else begin
      if (rx_push) begin
        rx_fifo[rx_wp] <= rx_word;
        rx_wp <= !rx_wp;
      end
      if (rx_pop) begin
        rx_rp <= !rx_rp;
      end
      rx_count <= rx_count + {1'b0, rx_push} - {1'b0, rx_pop};
    end
  end

  // overrun stays until continuous receive or the port is cleared
  always_ff @(posedge core_clk) begin
    if (srst || !serial_port_enable || !rx_cont) begin
      rx_overrun <= 1'b0;
    end else if (rx_ovr_ev) begin
      rx_overrun <= 1'b1;
    end
  end

  // (RL10) level flag, independent of any mask
  assign receive_interrupt_flag = serial_port_enable && rx_cont && (rx_count != 2'b00);

  // sticky event bits, write one to clear, a new event beats the clear
  assign int_ev[`SPTC_INT_RX_CHAR] = rx_push;
  assign int_ev[`SPTC_INT_TX_DONE] = tx_done;
  assign int_ev[`SPTC_INT_OVERRUN] = rx_ovr_ev;
  assign int_ev[`SPTC_INT_FRAME_ERR] = rx_ferr_ev;
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_int
      always_ff @(posedge core_clk) begin
        if (srst) begin
          int_stat[gi] <= 1'b0;
        end else if (int_ev[gi]) begin
          int_stat[gi] <= 1'b1;
        end else if (reg_wr && (reg_addr == `SPTC_ADDR_INT_STAT) && reg_wdata[gi]) begin
          int_stat[gi] <= 1'b0;
        end
      end
    end
  endgenerate
  // mask register
  always_ff @(posedge core_clk) begin
    if (srst) begin
      int_mask <= 4'h0;
    end else if (reg_wr && (reg_addr == `SPTC_ADDR_INT_MASK)) begin
      int_mask <= reg_wdata[3:0];
    end
  end
  assign irq = |(int_stat & int_mask);

  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  sequence s_tick_gap;
    (!bif.tick) [*3];
  endsequence
  sequence s_loaded;
    tx_load ##1 (tx_state != TX_IDLE);
  endsequence
  a_slave_no_clock: assert property (sync_mode && !clock_source_select |=> !sclk_oe) // RL1
    else $error("slave drives clock");
  a_eight_bit_len: assert property (!nine_bit_tx_select && tx_state == TX_DATA |-> // RL2
    tx_cnt < 4'h8) else $error("too many data bits");
  a_tx_disable: assert property (!transmit_enable_field |=> tx_state == TX_IDLE) // RL3
    else $error("transmitter busy while disabled");
  a_async_start: assert property (tx_load && !sync_mode |=> tx_state == TX_START) // RL4
    else $error("async character without start bit");
  a_bit3_zero: assert property (reg_rd && reg_addr == `SPTC_ADDR_TX_CTL |=> !reg_rdata[3]) // RL5
    else $error("unimplemented bit reads one");
  a_low_speed: assert property (bif.tick && !sync_mode && !baud_speed_select && bif.run // RL6
    && !$past(sync_mode) && !$past(baud_speed_select) |=> s_tick_gap)
    else $error("low speed tick too fast");
  a_empty_busy: assert property (s_loaded |-> !shift_register_empty) // RL7
    else $error("empty flag while shifting");
  a_ninth_out: assert property (tx_state == TX_DATA && tx_cnt == 4'h8 && // RL8
    transmit_enable_field |=> tx_line_out == $past(transmit_shift_register[0]))
    else $error("ninth bit not sent");
  a_reset_vals: assert property (disable iff (1'b0) srst |=> tx_ctl_view == // RL9
    `SPTC_TX_CTL_RESET) else $error("bad reset value");
  a_rx_flag: assert property (rx_push && rx_cont |=> receive_interrupt_flag) // RL10
    else $error("receive flag not set");
  a_write_lands: assert property (wr_tx_ctl |=> tx_ctl_view[7:4] == $past(reg_wdata[7:4])) // RL12
    else $error("control write not applied");
endmodule : sptc_serial_port

// file: bench/sptc_line_peer.sv
// remote serial device on the line side: sends async frames, captures sent ones
`timescale 1ns/1ps
module sptc_line_peer (
  // clock
  input wire logic core_clk,
  // line from the port
  input wire logic tx_line_out,
  input wire logic tx_line_oe,
  // frame shape chosen by the bench
  input wire logic [31:0] bit_cycles,
  input wire logic nine,
  // line to the port and capture results
  output logic rx_line_in,
  output logic sclk_in,
  output logic [8:0] got_char,
  output int got_count
);
  int i;
  // idle line high; clock parked low until clock_char clocks a sync slave character
  initial begin
    rx_line_in = 1'b1;
    sclk_in = 1'b0;
    got_char = 9'h000;
    got_count = 0;
  end
  // one frame: start low, data lsb first, stop high
  task send_char(input logic [7:0] d);
    rx_line_in <= 1'b0;
    repeat (bit_cycles) @(posedge core_clk);
    for (int k = 0; k < 8; k++) begin
      rx_line_in <= d[k];
      repeat (bit_cycles) @(posedge core_clk);
    end
    rx_line_in <= 1'b1;
    repeat (bit_cycles) @(posedge core_clk);
  endtask : send_char
  // sync slave clock: eight pulses, data taken just before each rise
  task clock_char(output logic [7:0] d);
    for (int k = 0; k < 8; k++) begin
      repeat (8) @(posedge core_clk);
      d[k] = tx_line_out;
      sclk_in <= 1'b1;
      repeat (8) @(posedge core_clk);
      sclk_in <= 1'b0;
    end
    repeat (8) @(posedge core_clk);
  endtask : clock_char
  // capture: start edge, then mid-bit samples; ends at mid stop bit
  always begin
    @(posedge core_clk);
    if (tx_line_oe === 1'b1 && tx_line_out === 1'b0) begin
      repeat (bit_cycles / 2) @(posedge core_clk);
      got_char = 9'h000;
      for (i = 0; i < (nine ? 9 : 8); i++) begin
        repeat (bit_cycles) @(posedge core_clk);
        got_char[i] = tx_line_out;
      end
      repeat (bit_cycles) @(posedge core_clk);
      got_count = got_count + 1;
    end
  end
endmodule : sptc_line_peer

// file: bench/sptc_serial_port_tb_top.sv
// self-checking bench for the serial port with a line-side peer
`timescale 1ns/1ps
module sptc_serial_port_tb_top;
  import sptc_pkg::*;
  logic core_clk, srst, reg_wr, reg_rd, tx_line_out, tx_line_oe, rx_line_in, sclk_in;
  logic sclk_out, sclk_oe, receive_interrupt_flag, irq, nine;
  sptc_byte_t reg_addr, reg_wdata, reg_rdata, neg_rdata;
  logic [8:0] got_char;
  logic [7:0] sync_in, sync_bits;
  logic sclk_d;
  logic [23:0] rows [9];
  int got_count, bit_cycles, num_errors, checks, cycles, r, sync_rises;
  sptc_serial_port i_dut (.core_clk(core_clk), .srst(srst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .rx_line_in(rx_line_in), .tx_line_out(tx_line_out), .tx_line_oe(tx_line_oe),
    .sclk_in(sclk_in), .sclk_out(sclk_out), .sclk_oe(sclk_oe),
    .receive_interrupt_flag(receive_interrupt_flag), .irq(irq));
  sptc_line_peer i_peer (.core_clk(core_clk), .tx_line_out(tx_line_out),
    .tx_line_oe(tx_line_oe), .bit_cycles(bit_cycles), .nine(nine), .rx_line_in(rx_line_in),
    .sclk_in(sclk_in), .got_char(got_char), .got_count(got_count));
  // 125 MHz clock
  always #4 core_clk = ~core_clk;
  // read data captured mid-cycle, away from the launching edge
  always @(negedge core_clk) neg_rdata <= reg_rdata;
  // sync master capture: data bit taken on each rise of the port's clock
  always @(posedge core_clk) begin
    sclk_d <= sclk_out;
    if (sclk_out && !sclk_d) begin
      sync_bits <= {tx_line_out, sync_bits[7:1]};
      sync_rises <= sync_rises + 1;
    end
  end
  // hang guard: far above the longest expected run
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors = num_errors + 1;
      results();
    end
  end
  task chk(input string what, input logic [8:0] exp, input logic [8:0] got);
    checks = checks + 1;
    if (got !== exp) begin
      num_errors = num_errors + 1;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask : cyc
  // one bus cycle; strobes come down only through the next call
  task xfer(input logic w, input logic rd, input sptc_byte_t a, input sptc_byte_t d);
    reg_wr <= w;
    reg_rd <= rd;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
  endtask : xfer
  task wr(input sptc_byte_t a, input sptc_byte_t d);
    xfer(1'b1, 1'b0, a, d);
    xfer(1'b0, 1'b0, a, d);
  endtask : wr
  task rd(input sptc_byte_t a, input sptc_byte_t exp, input string what);
    xfer(1'b0, 1'b1, a, 8'h00);
    xfer(1'b0, 1'b0, a, 8'h00);
    chk(what, {1'b0, exp}, {1'b0, neg_rdata});
  endtask : rd
  // send one character and compare what the peer captured
  task tx_char(input sptc_byte_t ctl, input sptc_byte_t d, input int bc, input logic [8:0] e);
    int c0;
    int n;
    bit_cycles = bc;
    nine = ctl[6];
    c0 = got_count;
    wr(8'h00, ctl);
    wr(8'h04, d);
    cyc(4);
    rd(8'h00, ctl & 8'hF5, "busy flag");
    chk("line enable", 9'h001, {8'h00, tx_line_oe});
    for (n = 0; n < 2000 && got_count == c0; n++) @(posedge core_clk);
    chk("tx char", e, got_char);
    cyc(bc);
    $display("test tx %h done", d);
  endtask : tx_char
  task results;
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : results
  initial begin
    {core_clk, reg_wr, reg_rd, nine, reg_addr, reg_wdata} = '0;
    {num_errors, checks, cycles, sync_rises} = '0;
    bit_cycles = 16;
    srst = 1'b1;
    // addr, write value, read back: bit 3 and status bits never take a write
    rows = '{24'h00FFF7, 24'h000802, 24'h02A5A5, 24'h020000, 24'h017F78,
      24'h010000, 24'h060F0F, 24'h050F00, 24'h10FF00};
    cyc(3);
    srst <= 1'b0;
    rd(8'h00, 8'h02, "reset tx ctl");
    rd(8'h01, 8'h00, "reset rx ctl");
    chk("idle pins", 9'h001, {6'h00, tx_line_oe, irq, tx_line_out});
    $display("test reset done");
    for (r = 0; r < 9; r++) begin
      xfer(1'b1, 1'b0, rows[r][23:16], rows[r][15:8]);
      rd(rows[r][23:16], rows[r][7:0], "reg table");
    end
    $display("test table done");
    wr(8'h01, 8'h80);
    tx_char(8'h24, 8'h55, 16, 9'h055);
    rd(8'h05, 8'h02, "tx done status");
    chk("irq set", 9'h001, {8'h00, irq});
    wr(8'h05, 8'h0F);
    chk("irq clear", 9'h000, {8'h00, irq});
    tx_char(8'h65, 8'hA3, 16, 9'h1A3);
    tx_char(8'h20, 8'h3C, 64, 9'h03C);
    wr(8'h00, 8'h90);
    cyc(2);
    chk("master clock", 9'h001, {8'h00, sclk_oe});
    wr(8'h00, 8'h10);
    cyc(2);
    chk("slave clock", 9'h000, {8'h00, sclk_oe});
    wr(8'h00, 8'h80);
    cyc(2);
    chk("async clock", 9'h000, {8'h00, sclk_oe});
    $display("test clock source done");
    wr(8'h00, 8'h24);
    wr(8'h04, 8'hFF);
    cyc(40);
    wr(8'h00, 8'h04);
    cyc(2);
    chk("abort pins", 9'h001, {7'h00, tx_line_oe, tx_line_out});
    rd(8'h00, 8'h06, "abort empty");
    cyc(300);
    $display("test abort done");
    bit_cycles = 16;
    wr(8'h05, 8'h0F);
    wr(8'h01, 8'h90);
    i_peer.send_char(8'h5A);
    for (r = 0; r < 200 && receive_interrupt_flag !== 1'b1; r++) @(posedge core_clk);
    chk("rx flag", 9'h003, {7'h00, receive_interrupt_flag, irq});
    wr(8'h06, 8'h00);
    chk("irq masked", 9'h000, {8'h00, irq});
    wr(8'h06, 8'h0F);
    rd(8'h03, 8'h5A, "rx data");
    chk("rx flag gone", 9'h000, {8'h00, receive_interrupt_flag});
    $display("test receive done");
    // sync master: port drives the clock, eight rises for eight bits
    sync_rises = 0;
    wr(8'h00, 8'hB0);
    wr(8'h04, 8'h96);
    cyc(60);
    chk("master data", 9'h096, {1'b0, sync_bits});
    chk("master clocks", 9'h008, sync_rises[8:0]);
    chk("master clock idle", 9'h000, {8'h00, sclk_out});
    // sync slave: the peer clocks the port
    wr(8'h00, 8'h30);
    wr(8'h04, 8'hC3);
    cyc(2);
    i_peer.clock_char(sync_in);
    chk("slave data", 9'h0C3, {1'b0, sync_in});
    rd(8'h00, 8'h32, "slave empty");
    $display("test sync done");
    wr(8'h00, 8'hE5);
    srst <= 1'b1;
    cyc(1);
    srst <= 1'b0;
    rd(8'h00, 8'h02, "mid reset");
    $display("test second reset done");
    results();
  end
endmodule : sptc_serial_port_tb_top
